// ==== logic/sss_pkg.sv ====
// Package with constants, types and the register map of the slow-speed sequencer.
package sss_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_S;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_TORQ = 8'h04;
  localparam logic [7:0] ADR_TIMES = 8'h08;
  localparam logic [7:0] ADR_CMD = 8'h0C;
  localparam logic [7:0] ADR_STATUS = 8'h10;
  localparam logic [7:0] ADR_START_TOT = 8'h14;
  localparam logic [7:0] ADR_START_CLR = 8'h18;
  localparam logic [7:0] ADR_RUN_TOT = 8'h1C;
  localparam logic [7:0] ADR_RUN_CLR = 8'h20;
  localparam logic [7:0] ADR_TRIP = 8'h24;
  localparam logic [7:0] ADR_ENERGY = 8'h28;
  localparam logic [6:0] TORQ_MIN = 7'h1E;
  localparam logic [6:0] TORQ_MAX = 7'h63;
  localparam logic [6:0] TORQ_RST = 7'h1E;
  localparam logic [5:0] TIME_MAX = 6'h3C;
  localparam logic [5:0] TIMEOUT_RST = 6'h00;
  localparam logic [5:0] DWELL_RST = 6'h00;
  localparam logic [5:0] DECEL_RST = 6'h00;
  localparam logic [16:0] START_MAX = 17'h1_869F;
  localparam logic [16:0] HOUR_MAX = 17'h1_869F;
  localparam logic [5:0] MIN_MAX = 6'h3B;
  localparam logic [5:0] SEC_MAX = 6'h3B;
  localparam logic [6:0] TRIP_MAX = 7'h63;
  localparam logic [19:0] ENERGY_MAX = 20'hF_423F;
  localparam logic [2:0] DI_OPT_FWD = 3'h6;
  localparam logic [2:0] DI_OPT_REV = 3'h7;
  localparam logic [4:0] FAULT_JOG_TIMEOUT = 5'h12;

  typedef struct packed {
    logic [16:0] hours;
    logic [5:0] minutes;
    logic [5:0] seconds;
  } sss_time_s;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_DWELL = 6'b00_0010,
    ST_RAMP = 6'b00_0100,
    ST_DECEL = 6'b00_1000,
    ST_REVJOG = 6'b01_0000,
    ST_TRIP = 6'b10_0000
  } sss_state_e;
endpackage : sss_pkg

// ==== logic/sss_run_timer.sv ====
// Saturating hours, minutes and seconds run-time accumulator.
`timescale 1ns/1ps
`default_nettype none
module sss_run_timer
  import sss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic tick,
  input wire logic running,
  input wire logic clear,
  output sss_time_s value
);
  always_ff @(posedge ref_clk) begin
    if (!rst_b || clear) begin
      value <= '0;
    end else if (tick && running && !(value.hours == HOUR_MAX && value.minutes == MIN_MAX)) begin
      if (value.seconds != SEC_MAX) begin
        value.seconds <= value.seconds + 6'h1;
      end else begin
        value.seconds <= '0;
        if (value.minutes != MIN_MAX) begin
          value.minutes <= value.minutes + 6'h1;
        end else begin
          value.minutes <= '0;
          value.hours <= value.hours + 17'h1;
        end
      end
    end
  end
endmodule : sss_run_timer
`default_nettype wire

// ==== logic/sss_jog_seq.sv ====
// Slow-speed sequencer with operating statistics and a classic Wishbone register slave.
//
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module sss_jog_seq
  import sss_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES,
  parameter int unsigned NUM_DI = 4
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_stb_i,
  input wire logic wb_cyc_i,
  output logic wb_ack_o,
  input wire logic start_key,
  input wire logic stop_key,
  input wire logic [NUM_DI-1:0] di_level,
  input wire logic [3*NUM_DI-1:0] di_option,
  input wire logic run_cmd,
  input wire logic ramp_done,
  input wire logic decel_done,
  input wire logic fault_trip,
  input wire logic energy_pulse,
  output logic jog_fwd,
  output logic jog_rev,
  output logic ramp_run,
  output logic [6:0] jog_torque,
  output logic jog_timeout_fault,
  output logic [4:0] fault_code
);
  if (TICK_DIV < 2 || NUM_DI < 1 || NUM_DI > 8) begin : g_bad_params
    $error("sss_jog_seq: unsupported parameter values");
  end

  logic [31:0] tick_cnt;
  logic tick, wr, rd_req;
  logic keypad_jog_mode, jog_ramp_enable, dwell_off;
  logic [6:0] jog_torque_level;
  logic [5:0] jog_pre_ramp_dwell, jog_post_ramp_dwell, jog_timeout;
  logic clear_start_count_cmd, clear_run_time_cmd, clear_trip_count_cmd, fault_clear_cmd;
  logic [16:0] total_start_count, clearable_start_count;
  logic [6:0] total_trip_count, clearable_trip_count;
  logic [19:0] energy_total;
  sss_time_s total_run_time, clearable_run_time;
  sss_state_e state, next_state;
  logic [5:0] phase_sec, jog_sec;
  logic run_cmd_q, start_event, trip_event, motor_running;
  logic di_fwd, di_rev, key_fwd, key_rev, jog_any, next_jog_fwd, next_jog_rev;

  function automatic logic [16:0] sat_inc17(input logic [16:0] v, input logic [16:0] lim);
    sat_inc17 = (v == lim) ? v : v + 17'h1;
  endfunction : sat_inc17

  function automatic logic [6:0] sat_inc7(input logic [6:0] v, input logic [6:0] lim);
    sat_inc7 = (v == lim) ? v : v + 7'h1;
  endfunction : sat_inc7

  function automatic logic [6:0] clamp_torque(input logic [6:0] v);
    if (v < TORQ_MIN) begin
      clamp_torque = TORQ_MIN;
    end else if (v > TORQ_MAX) begin
      clamp_torque = TORQ_MAX;
    end else begin
      clamp_torque = v;
    end
  endfunction : clamp_torque

  function automatic logic [5:0] clamp_time(input logic [5:0] v);
    clamp_time = (v > TIME_MAX) ? TIME_MAX : v;
  endfunction : clamp_time

  // One second tick shared by every timer.
  always_ff @(posedge ref_clk) begin
    if (!rst_b || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end
  assign tick = (tick_cnt == TICK_DIV - 1);

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // Configuration registers.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      keypad_jog_mode <= 1'b0;
      jog_ramp_enable <= 1'b0;
      dwell_off <= 1'b0;
      jog_torque_level <= TORQ_RST;
      jog_pre_ramp_dwell <= DWELL_RST;
      jog_post_ramp_dwell <= DECEL_RST;
      jog_timeout <= TIMEOUT_RST;
    end else if (wr) begin
      if (wb_adr_i == ADR_CTRL && wb_sel_i[0]) begin
        keypad_jog_mode <= wb_dat_i[0];
        jog_ramp_enable <= wb_dat_i[1];
        dwell_off <= wb_dat_i[2];
      end
      if (wb_adr_i == ADR_TORQ && wb_sel_i[0]) begin
        jog_torque_level <= clamp_torque(wb_dat_i[6:0]);
      end
      if (wb_adr_i == ADR_TIMES) begin
        if (wb_sel_i[0]) begin
          jog_pre_ramp_dwell <= clamp_time(wb_dat_i[5:0]);
        end
        if (wb_sel_i[1]) begin
          jog_post_ramp_dwell <= clamp_time(wb_dat_i[13:8]);
        end
        if (wb_sel_i[2]) begin
          jog_timeout <= clamp_time(wb_dat_i[21:16]);
        end
      end
    end
  end

  // Command register bits are one-cycle pulses.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      clear_start_count_cmd <= 1'b0;
      clear_run_time_cmd <= 1'b0;
      clear_trip_count_cmd <= 1'b0;
      fault_clear_cmd <= 1'b0;
    end else begin
      clear_start_count_cmd <= wr && wb_adr_i == ADR_CMD && wb_sel_i[0] && wb_dat_i[0];
      clear_run_time_cmd <= wr && wb_adr_i == ADR_CMD && wb_sel_i[0] && wb_dat_i[1];
      clear_trip_count_cmd <= wr && wb_adr_i == ADR_CMD && wb_sel_i[0] && wb_dat_i[2];
      fault_clear_cmd <= wr && wb_adr_i == ADR_CMD && wb_sel_i[0] && wb_dat_i[3];
    end
  end

  // Digital input jog requests.
  always_comb begin
    di_fwd = 1'b0;
    di_rev = 1'b0;
    for (int i = 0; i < NUM_DI; i++) begin
      if (di_level[i] && di_option[3*i +: 3] == DI_OPT_FWD) begin
        di_fwd = 1'b1;
      end
      if (di_level[i] && di_option[3*i +: 3] == DI_OPT_REV) begin
        di_rev = 1'b1;
      end
    end
  end

  assign key_fwd = keypad_jog_mode && start_key && !stop_key;
  assign key_rev = keypad_jog_mode && stop_key && !start_key;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      run_cmd_q <= 1'b0;
    end else begin
      run_cmd_q <= run_cmd;
    end
  end
  assign start_event = (run_cmd && !run_cmd_q && state == ST_IDLE) || (key_fwd && !jog_fwd && state == ST_IDLE);
  assign trip_event = (fault_trip || next_state == ST_TRIP && state != ST_TRIP);

  // Automatic sequence around the ramp.
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (run_cmd && !run_cmd_q) begin
          next_state = (jog_ramp_enable && !dwell_off && jog_pre_ramp_dwell != 6'h0) ? ST_DWELL : ST_RAMP;
        end
      end
      ST_DWELL: begin
        if (!run_cmd) begin
          next_state = ST_IDLE;
        end else if (tick && phase_sec + 6'h1 >= jog_pre_ramp_dwell) begin
          next_state = ST_RAMP;
        end
      end
      ST_RAMP: begin
        if (!run_cmd) begin
          next_state = ST_DECEL;
        end
      end
      ST_DECEL: begin
        if (decel_done) begin
          next_state = (jog_ramp_enable && jog_post_ramp_dwell != 6'h0) ? ST_REVJOG : ST_IDLE;
        end
      end
      ST_REVJOG: begin
        if (tick && phase_sec + 6'h1 >= jog_post_ramp_dwell) begin
          next_state = ST_IDLE;
        end
      end
      ST_TRIP: begin
        if (fault_clear_cmd) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (jog_any && jog_timeout != 6'h0 && tick && jog_sec >= jog_timeout) begin
      next_state = ST_TRIP;
    end
    if (fault_trip) begin
      next_state = ST_TRIP;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b || next_state != state) begin
      phase_sec <= '0;
    end else if (tick && phase_sec != TIME_MAX) begin
      phase_sec <= phase_sec + 6'h1;
    end
  end

  assign jog_any = (state == ST_DWELL) || (state == ST_REVJOG) ||
                   ((state == ST_IDLE) && (key_fwd || key_rev || di_fwd || di_rev));
  assign next_jog_fwd = next_state == ST_DWELL ||
                        (next_state == ST_IDLE && state == ST_IDLE && (key_fwd || di_fwd) && !di_rev);
  assign next_jog_rev = next_state == ST_REVJOG ||
                        (next_state == ST_IDLE && state == ST_IDLE && (key_rev || di_rev) && !di_fwd);

  // Continuous slow-speed time.
  always_ff @(posedge ref_clk) begin
    if (!rst_b || !jog_any) begin
      jog_sec <= '0;
    end else if (tick && jog_sec != TIME_MAX) begin
      jog_sec <= jog_sec + 6'h1;
    end
  end

  // Outputs to the power stage.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      jog_fwd <= 1'b0;
      jog_rev <= 1'b0;
      ramp_run <= 1'b0;
      jog_torque <= '0;
      jog_timeout_fault <= 1'b0;
      fault_code <= '0;
    end else begin
      jog_fwd <= next_jog_fwd;
      jog_rev <= next_jog_rev;
      ramp_run <= next_state == ST_RAMP;
      jog_torque <= (next_jog_fwd || next_jog_rev) ? jog_torque_level : 7'h00;
      if (next_state == ST_TRIP && state != ST_TRIP && !fault_trip) begin
        jog_timeout_fault <= 1'b1;
        fault_code <= FAULT_JOG_TIMEOUT;
      end else if (fault_clear_cmd) begin
        jog_timeout_fault <= 1'b0;
        fault_code <= '0;
      end
    end
  end

  assign motor_running = jog_fwd || jog_rev || ramp_run || state == ST_DECEL;

  // Start, trip and energy statistics.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      total_start_count <= '0;
      clearable_start_count <= '0;
      total_trip_count <= '0;
      clearable_trip_count <= '0;
      energy_total <= '0;
    end else begin
      if (start_event) begin
        total_start_count <= sat_inc17(total_start_count, START_MAX);
        clearable_start_count <= sat_inc17(clearable_start_count, START_MAX);
      end else if (clear_start_count_cmd) begin
        clearable_start_count <= '0;
      end
      if (trip_event) begin
        total_trip_count <= sat_inc7(total_trip_count, TRIP_MAX);
        clearable_trip_count <= sat_inc7(clearable_trip_count, TRIP_MAX);
      end else if (clear_trip_count_cmd) begin
        clearable_trip_count <= '0;
      end
      if (energy_pulse && energy_total != ENERGY_MAX) begin
        energy_total <= energy_total + 20'h1;
      end
    end
  end

  sss_run_timer u_total_time (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .tick(tick),
    .running(motor_running),
    .clear(1'b0),
    .value(total_run_time)
  );

  sss_run_timer u_clear_time (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .tick(tick),
    .running(motor_running),
    .clear(clear_run_time_cmd),
    .value(clearable_run_time)
  );

  // Read data.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wb_dat_o <= '0;
    end else if (rd_req) begin
      case (wb_adr_i)
        ADR_CTRL: wb_dat_o <= {29'h0, dwell_off, jog_ramp_enable, keypad_jog_mode};
        ADR_TORQ: wb_dat_o <= {25'h0, jog_torque_level};
        ADR_TIMES: wb_dat_o <= {10'h0, jog_timeout, 2'h0, jog_post_ramp_dwell, 2'h0, jog_pre_ramp_dwell};
        ADR_STATUS: wb_dat_o <= {17'h0, fault_code, ramp_done, jog_timeout_fault, state, jog_rev, jog_fwd};
        ADR_START_TOT: wb_dat_o <= {15'h0, total_start_count};
        ADR_START_CLR: wb_dat_o <= {15'h0, clearable_start_count};
        ADR_RUN_TOT: wb_dat_o <= {3'h0, total_run_time.hours, 6'h0, total_run_time.minutes};
        ADR_RUN_CLR: wb_dat_o <= {3'h0, clearable_run_time.hours, 6'h0, clearable_run_time.minutes};
        ADR_TRIP: wb_dat_o <= {9'h0, clearable_trip_count, 9'h0, total_trip_count};
        ADR_ENERGY: wb_dat_o <= {12'h0, energy_total};
        default: wb_dat_o <= '0;
      endcase
    end
  end
endmodule : sss_jog_seq
`default_nettype wire

// ==== dv/sss_jog_seq_asserts.sv ====
// Port assertions and covers for the slow-speed sequencer.
`timescale 1ns/1ps
`default_nettype none
module sss_jog_seq_chk
  import sss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] wb_adr_i,
  input wire logic wb_we_i,
  input wire logic wb_stb_i,
  input wire logic wb_cyc_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic jog_fwd,
  input wire logic jog_rev,
  input wire logic ramp_run,
  input wire logic [6:0] jog_torque,
  input wire logic jog_timeout_fault,
  input wire logic [4:0] fault_code
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_excl; !(jog_fwd && jog_rev); endproperty
  a_excl: assert property (p_excl) else $error("both jog directions");
  property p_torq; (jog_fwd || jog_rev) |-> jog_torque >= TORQ_MIN && jog_torque <= TORQ_MAX; endproperty
  a_torq: assert property (p_torq) else $error("jog torque out of range");
  property p_torq_off; !(jog_fwd || jog_rev) |-> jog_torque == 7'h00; endproperty
  a_torq_off: assert property (p_torq_off) else $error("torque while not jogging");
  property p_code; jog_timeout_fault |-> fault_code == FAULT_JOG_TIMEOUT; endproperty
  a_code: assert property (p_code) else $error("wrong fault code");
  property p_cause; $rose(jog_timeout_fault) |-> $past(jog_fwd || jog_rev); endproperty
  a_cause: assert property (p_cause) else $error("timeout without jog");
  property p_halt; jog_timeout_fault && $past(jog_timeout_fault) |-> !jog_fwd && !jog_rev && !ramp_run; endproperty
  a_halt: assert property (p_halt) else $error("motor driven in fault");
  property p_ramp; ramp_run |-> !jog_fwd && !jog_rev; endproperty
  a_ramp: assert property (p_ramp) else $error("jog during ramp");
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus ack timing");
  property p_unmap; wb_ack_o && !wb_we_i && wb_adr_i > ADR_ENERGY |-> wb_dat_o == 32'h0000_0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  c_fwd: cover property ($rose(jog_fwd));
  c_ramp: cover property ($rose(ramp_run));
  c_flt: cover property ($rose(jog_timeout_fault));
endmodule : sss_jog_seq_chk
bind sss_jog_seq sss_jog_seq_chk chk_u (.ref_clk(ref_clk), .rst_b(rst_b), .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i),
  .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .jog_fwd(jog_fwd),
  .jog_rev(jog_rev), .ramp_run(ramp_run), .jog_torque(jog_torque), .jog_timeout_fault(jog_timeout_fault),
  .fault_code(fault_code));
`default_nettype wire

// ==== dv/sss_stage_model.sv ====
// Power stage model giving ramp status, deceleration end and energy pulses.
`timescale 1ns/1ps
`default_nettype none
module sss_stage_model (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic run_cmd,
  input wire logic ramp_run,
  output logic ramp_done,
  output logic decel_done,
  output logic energy_pulse
);
  logic spin;
  logic [3:0] cnt;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) cnt <= 4'h0;
    else cnt <= cnt + 4'h1;
    ramp_done <= ramp_run;
    energy_pulse <= rst_b && ramp_run && cnt == 4'hF;
    decel_done <= rst_b && spin && !run_cmd && cnt == 4'h7;
    if (!rst_b || decel_done) spin <= 1'b0;
    else if (ramp_run && run_cmd) spin <= 1'b1;
  end
endmodule : sss_stage_model
`default_nettype wire

// ==== dv/slow_speed_sequencer_with_statistics_tb.sv ====
// Self-checking testbench for the slow-speed sequencer.
`timescale 1ns/1ps
`default_nettype none
module slow_speed_sequencer_with_statistics_tb;
  import sss_pkg::*;
  localparam int TD = 10;
  logic ref_clk = 0, rst_b = 0, wb_we_i = 0, wb_stb_i = 0, wb_cyc_i = 0, start_key = 0, stop_key = 0;
  logic run_cmd = 0, fault_trip = 0, wb_ack_o, ramp_done, decel_done, energy_pulse;
  logic jog_fwd, jog_rev, ramp_run, jog_timeout_fault;
  logic [7:0] wb_adr_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, rq;
  logic [3:0] wb_sel_i = 4'hF, di_level = 0;
  logic [11:0] di_option = 0;
  logic [6:0] jog_torque;
  logic [4:0] fault_code;
  int errors = 0, n_tests = 0, epulses = 0, nc;
  wire logic [3:0] outs = {jog_timeout_fault, ramp_run, jog_rev, jog_fwd};
  sss_jog_seq #(.TICK_DIV(TD), .NUM_DI(4)) dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_stb_i(wb_stb_i),
    .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o), .start_key(start_key), .stop_key(stop_key), .di_level(di_level),
    .di_option(di_option), .run_cmd(run_cmd), .ramp_done(ramp_done), .decel_done(decel_done),
    .fault_trip(fault_trip), .energy_pulse(energy_pulse), .jog_fwd(jog_fwd), .jog_rev(jog_rev),
    .ramp_run(ramp_run), .jog_torque(jog_torque), .jog_timeout_fault(jog_timeout_fault), .fault_code(fault_code));
  sss_stage_model stage_u (.ref_clk(ref_clk), .rst_b(rst_b), .run_cmd(run_cmd), .ramp_run(ramp_run),
    .ramp_done(ramp_done), .decel_done(decel_done), .energy_pulse(energy_pulse));
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (energy_pulse === 1'b1) epulses++;
  task automatic summarize;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
      if (i > 20) begin
        chk("ack", 1, 0);
        summarize;
      end
    end while (wb_ack_o !== 1'b1);
    rq = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  task automatic chkr(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(a, 0, 0);
    chk(nm, exp, rq);
  endtask : chkr
  task automatic wt(input int k, input logic v, input int lim);
    nc = 0;
    while (outs[k] !== v) begin
      @(posedge ref_clk);
      nc++;
      if (nc > lim) begin
        chk("wait", 32'(v), 32'(outs[k]));
        summarize;
      end
    end
  endtask : wt
  task automatic t_regs;
    logic [15:0] tq [5] = '{16'h051E, 16'h1E1E, 16'h6363, 16'h7863, 16'h3232};
    chkr("ctrl", ADR_CTRL, 0);
    chkr("torq", ADR_TORQ, 32'(TORQ_RST));
    chkr("times", ADR_TIMES, 0);
    for (int a = 5; a <= 10; a++) chkr("stat", 8'(a * 4), 0);
    bus(8'h3C, 1, 32'hFFFF_FFFF);
    chkr("unmapped", 8'h3C, 0);
    bus(ADR_TIMES, 1, 32'h003F_3F3F);
    chkr("clamp", ADR_TIMES, 32'h003C_3C3C);
    foreach (tq[i]) begin
      bus(ADR_TORQ, 1, 32'(tq[i][15:8]));
      chkr("torq", ADR_TORQ, 32'(tq[i][7:0]));
    end
  endtask : t_regs
  task automatic t_keypad;
    logic [31:0] s0;
    bus(ADR_START_TOT, 0, 0);
    s0 = rq;
    bus(ADR_CTRL, 1, 32'h0000_0001);
    start_key <= 1'b1;
    wt(0, 1, 8);
    chk("torque", 32'h0000_0032, 32'(jog_torque));
    chk("rev", 0, 32'(jog_rev));
    start_key <= 1'b0;
    wt(0, 0, 8);
    stop_key <= 1'b1;
    wt(1, 1, 8);
    chk("fwd", 0, 32'(jog_fwd));
    stop_key <= 1'b0;
    wt(1, 0, 8);
    chkr("starts", ADR_START_TOT, s0 + 1);
    bus(ADR_CTRL, 1, 0);
  endtask : t_keypad
  task automatic t_di;
    logic [2:0] op [3] = '{3'h6, 3'h7, 3'h5};
    foreach (op[i]) begin
      di_option <= 12'(op[i]) << 6;
      di_level <= 4'h4;
      repeat (4) @(posedge ref_clk);
      chk("di_fwd", 32'(op[i] == DI_OPT_FWD), 32'(jog_fwd));
      chk("di_rev", 32'(op[i] == DI_OPT_REV), 32'(jog_rev));
      di_level <= 4'h0;
      repeat (4) @(posedge ref_clk);
      chk("di_off", 0, 32'({jog_fwd, jog_rev}));
    end
  endtask : t_di
  task automatic t_auto(input logic en, input int hold);
    logic [31:0] s0, c0;
    bus(ADR_TIMES, 1, 32'h0000_0302);
    bus(ADR_CTRL, 1, 32'(en) << 1);
    bus(ADR_START_TOT, 0, 0);
    s0 = rq;
    bus(ADR_START_CLR, 0, 0);
    c0 = rq;
    run_cmd <= 1'b1;
    if (en) begin
      wt(0, 1, 8);
      wt(0, 0, 4 * TD);
      chk("dwell", 1, 32'(nc > TD && nc <= 3 * TD));
    end
    wt(2, 1, 5);
    repeat (hold) @(posedge ref_clk);
    run_cmd <= 1'b0;
    if (en) begin
      wt(1, 1, 40);
      wt(1, 0, 5 * TD);
      chk("rev_dwell", 1, 32'(nc > 2 * TD && nc <= 4 * TD));
    end else begin
      repeat (15) @(posedge ref_clk);
      chk("no_rev", 0, 32'(jog_rev));
    end
    chkr("starts", ADR_START_TOT, s0 + 1);
    chkr("clearable_start_count", ADR_START_CLR, c0 + 1);
    chkr("energy", ADR_ENERGY, 32'(epulses));
  endtask : t_auto
  task automatic t_trip;
    logic [31:0] t0;
    bus(ADR_TIMES, 1, 32'h0003_0000);
    bus(ADR_CTRL, 1, 32'h0000_0001);
    bus(ADR_TRIP, 0, 0);
    t0 = rq;
    start_key <= 1'b1;
    wt(0, 1, 8);
    wt(3, 1, 6 * TD);
    chk("timeout", 1, 32'(nc >= 2 * TD && nc <= 4 * TD + 4));
    chk("code", 32'(FAULT_JOG_TIMEOUT), 32'(fault_code));
    chkr("status", ADR_STATUS, 32'h0000_0100 | (32'(ST_TRIP) << 2) | (32'(FAULT_JOG_TIMEOUT) << 10));
    start_key <= 1'b0;
    wt(0, 0, 2);
    chkr("trips", ADR_TRIP, t0 + 32'h0001_0001);
    bus(ADR_CMD, 1, 32'h0000_0004);
    chkr("trips_clr", ADR_TRIP, 32'(t0[6:0]) + 1);
    bus(ADR_CMD, 1, 32'h0000_0008);
    wt(3, 0, 4);
    bus(ADR_START_TOT, 0, 0);
    t0 = rq;
    bus(ADR_CMD, 1, 32'h0000_0001);
    chkr("clearable_start_count", ADR_START_CLR, 0);
    chkr("total_start_count", ADR_START_TOT, t0);
    bus(ADR_CMD, 1, 32'h0000_0002);
    chkr("run2", ADR_RUN_CLR, 0);
    chkr("run1", ADR_RUN_TOT, 32'h0000_0002);
    bus(ADR_TRIP, 0, 0);
    t0 = rq;
    fault_trip <= 1'b1;
    @(posedge ref_clk);
    fault_trip <= 1'b0;
    chkr("trips_ext", ADR_TRIP, t0 + 32'h0001_0001);
  endtask : t_trip
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs;
    t_keypad;
    t_di;
    t_auto(1'b0, 1250);
    chkr("run1", ADR_RUN_TOT, 32'h0000_0002);
    chkr("run2", ADR_RUN_CLR, 32'h0000_0002);
    t_auto(1'b1, 50);
    t_trip;
    summarize;
  end
endmodule : slow_speed_sequencer_with_statistics_tb
`default_nettype wire
